// >>> design/frc_encoder.sv
// Report frame encoder: registers over Wishbone, frame builder, output FIFO.
// Assumes a classic Wishbone master and a byte sink with valid/ready.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module frc_encoder #(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Frame byte stream
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_last
);
    // ==========================================================
    // Registers
    logic [7:0]  ctrl_flags;
    logic [31:0] temp_reg;
    logic [31:0] lat_reg;
    logic [31:0] lon_reg;
    logic [31:0] misc_reg;
    logic [7:0]  last_hdr;
    logic [7:0]  sent_cnt;
    logic        send_req;
    logic        wb_hit;
    logic        wb_wr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_hit & wb_we_i;

    // One wait state: ack the cycle after the request is seen
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            temp_reg <= frc_pkg::RST_WORD;
            lat_reg  <= frc_pkg::RST_WORD;
            lon_reg  <= frc_pkg::RST_WORD;
            misc_reg <= frc_pkg::RST_WORD;
        end else if (wb_wr) begin
            case (wb_adr_i)
                frc_pkg::REG_TEMP: temp_reg <= merge(temp_reg, wb_dat_i, wb_sel_i);
                frc_pkg::REG_LAT:  lat_reg  <= merge(lat_reg, wb_dat_i, wb_sel_i);
                frc_pkg::REG_LON:  lon_reg  <= merge(lon_reg, wb_dat_i, wb_sel_i);
                frc_pkg::REG_MISC: misc_reg <= merge(misc_reg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // Bit 0 of the flags is never stored, so it always goes out as zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_flags <= frc_pkg::RST_BYTE;
            send_req   <= 1'b0;
        end else begin
            send_req <= 1'b0;
            if (wb_wr && wb_adr_i == frc_pkg::REG_CTRL && wb_sel_i[0]) begin
                ctrl_flags <= {wb_dat_i[7:1], 1'b0};
                send_req   <= wb_dat_i[frc_pkg::CTRL_SEND_BIT];
            end
        end
    end

    // ==========================================================
    // Frame builder
    frc_pkg::frc_state_e state;
    frc_pkg::frc_field_e field;
    logic [3:0]  byte_idx;
    logic [7:0]  hdr;
    logic [7:0]  cur_byte;
    logic [3:0]  cur_len;
    logic        field_on;
    logic        is_last;
    logic        f_valid;
    logic        f_ready;
    frc_pkg::frc_byte_s f_byte;
    logic [31:0] lat_word;

    // Latitude word: byte one deg, two min, three frac 1-2, four frac 3 + hemisphere
    assign lat_word = {lat_reg[31:4], 3'b000, lat_reg[0]};

    // Flag of each field in the captured status byte
    function automatic logic field_present(input frc_pkg::frc_field_e f, input logic [7:0] h);
        case (f)
            frc_pkg::F_STATUS: field_present = 1'b1;
            frc_pkg::F_TEMP:   field_present = h[frc_pkg::ST_TEMP_BIT];
            frc_pkg::F_LAT:    field_present = h[frc_pkg::ST_POS_BIT];
            frc_pkg::F_LON:    field_present = h[frc_pkg::ST_POS_BIT];
            frc_pkg::F_QUAL:   field_present = h[frc_pkg::ST_POS_BIT];
            frc_pkg::F_ULCNT:  field_present = h[frc_pkg::ST_ULCNT_BIT];
            frc_pkg::F_DLCNT:  field_present = h[frc_pkg::ST_DLCNT_BIT];
            frc_pkg::F_BATT:   field_present = h[frc_pkg::ST_BATT_BIT];
            default:           field_present = 1'b0;
        endcase
    endfunction : field_present

    function automatic frc_pkg::frc_field_e next_of(input frc_pkg::frc_field_e f);
        next_of = frc_pkg::frc_field_e'({f[6:0], 1'b0});
    endfunction : next_of

    // Any present field after the given one
    function automatic logic more_after(input frc_pkg::frc_field_e f, input logic [7:0] h);
        logic m;
        m = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (f[i] == 1'b0 && (f < frc_pkg::frc_field_e'(8'h01 << i))) begin
                m = m | field_present(frc_pkg::frc_field_e'(8'h01 << i), h);
            end
        end
        return m;
    endfunction : more_after

    always_comb begin
        cur_byte = 8'h00;
        cur_len  = 4'h1;
        case (field)
            frc_pkg::F_STATUS: cur_byte = hdr;
            frc_pkg::F_TEMP:   cur_byte = temp_reg[7:0];
            frc_pkg::F_LAT: begin
                cur_len  = frc_pkg::LEN_LAT;
                cur_byte = lat_word[8*(3-byte_idx[1:0]) +: 8];
            end
            frc_pkg::F_LON: begin
                cur_len  = frc_pkg::LEN_LON;
                cur_byte = lon_reg[8*(3-byte_idx[1:0]) +: 8];
            end
            frc_pkg::F_QUAL:   cur_byte = misc_reg[frc_pkg::MISC_QUAL_LSB +: 8];
            frc_pkg::F_ULCNT:  cur_byte = misc_reg[frc_pkg::MISC_UL_LSB +: 8];
            frc_pkg::F_DLCNT:  cur_byte = misc_reg[frc_pkg::MISC_DL_LSB +: 8];
            frc_pkg::F_BATT: begin
                cur_len  = frc_pkg::LEN_BATT;
                cur_byte = byte_idx[0] ? temp_reg[frc_pkg::TEMP_BATT_LSB +: 8]
                                       : temp_reg[frc_pkg::TEMP_BATT_LSB + 8 +: 8];
            end
            default: ;
        endcase
    end

    assign field_on    = field_present(field, hdr);
    assign is_last     = (byte_idx == cur_len - 4'h1) && !more_after(field, hdr);
    assign f_valid     = (state == frc_pkg::S_SEND) && field_on;
    assign f_byte.data = cur_byte;
    assign f_byte.last = is_last;

    // Header is frozen at start so a register write mid-frame cannot
    // make the status byte disagree with the fields that follow.
    always_ff @(posedge mclk) begin
        if (reset) begin
            state    <= frc_pkg::S_IDLE;
            field    <= frc_pkg::F_STATUS;
            byte_idx <= 4'h0;
            hdr      <= frc_pkg::RST_BYTE;
            last_hdr <= frc_pkg::RST_BYTE;
            sent_cnt <= frc_pkg::RST_BYTE;
        end else begin
            case (state)
                frc_pkg::S_IDLE: begin
                    if (send_req) begin
                        hdr      <= ctrl_flags;
                        field    <= frc_pkg::F_STATUS;
                        byte_idx <= 4'h0;
                        state    <= frc_pkg::S_SEND;
                    end
                end
                frc_pkg::S_SEND: begin
                    if (!field_on) begin
                        field    <= next_of(field);
                        byte_idx <= 4'h0;
                    end else if (f_ready) begin
                        if (is_last) begin
                            state    <= frc_pkg::S_IDLE;
                            last_hdr <= hdr;
                            sent_cnt <= sent_cnt + 8'h01;
                        end else if (byte_idx == cur_len - 4'h1) begin
                            field    <= next_of(field);
                            byte_idx <= 4'h0;
                        end else begin
                            byte_idx <= byte_idx + 4'h1;
                        end
                    end
                end
                default: state <= frc_pkg::S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Output FIFO; a full FIFO stalls the builder
    logic        q_valid;
    logic [8:0]  q_data;
    logic        q_take;

    frc_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_byte),
        .out_valid (q_valid),
        .out_ready (q_take),
        .out_data  (q_data)
    );

    // Output register stage keeps ports straight from flip-flops
    assign q_take = q_valid && (!tx_valid || tx_ready);

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else if (!tx_valid || tx_ready) begin
            tx_valid <= q_valid;
            tx_data  <= q_data[7:0];
            tx_last  <= q_data[8];
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_dat_o <= frc_pkg::RST_WORD;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                frc_pkg::REG_CTRL:    wb_dat_o <= {24'h00_0000, ctrl_flags};
                frc_pkg::REG_TEMP:    wb_dat_o <= temp_reg;
                frc_pkg::REG_LAT:     wb_dat_o <= lat_reg;
                frc_pkg::REG_LON:     wb_dat_o <= lon_reg;
                frc_pkg::REG_MISC:    wb_dat_o <= misc_reg;
                frc_pkg::REG_STATUS:  wb_dat_o <= {16'h0000, sent_cnt, 7'h00, state == frc_pkg::S_SEND};
                frc_pkg::REG_LASTHDR: wb_dat_o <= {24'h00_0000, last_hdr};
                default:              wb_dat_o <= frc_pkg::RST_WORD;
            endcase
        end
    end

    // ==========================================================
    // Checks
    first_is_hdr_a: assert property (@(posedge mclk) disable iff (reset)
        (state == frc_pkg::S_IDLE && send_req) |=> (field == frc_pkg::F_STATUS && byte_idx == 4'h0))
        else $error("frame does not start with status");
    bit0_zero_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && field == frc_pkg::F_STATUS) |-> (cur_byte[0] == 1'b0))
        else $error("status bit 0 not zero");
    temp_gate_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && field == frc_pkg::F_TEMP) |-> hdr[7])
        else $error("temperature sent without flag");
    pos_gate_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && (field == frc_pkg::F_LAT || field == frc_pkg::F_QUAL)) |-> hdr[4])
        else $error("position sent without flag");
    ul_gate_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && field == frc_pkg::F_ULCNT) |-> hdr[3])
        else $error("uplink counter sent without flag");
    dl_gate_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && field == frc_pkg::F_DLCNT) |-> hdr[2])
        else $error("downlink counter sent without flag");
    batt_order_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && f_ready && field == frc_pkg::F_BATT && byte_idx == 4'h0 && hdr[1])
        |=> (f_byte.data == temp_reg[23:16]) [*1] ##0 (byte_idx == 4'h1))
        else $error("battery byte order wrong");
    lat_pad_a: assert property (@(posedge mclk) disable iff (reset)
        (f_valid && field == frc_pkg::F_LAT && byte_idx == 4'h3) |-> (cur_byte[3:1] == 3'b000))
        else $error("latitude unused bits not zero");
    order_a: assert property (@(posedge mclk) disable iff (reset)
        (state == frc_pkg::S_SEND && $past(state) == frc_pkg::S_SEND) |-> (field >= $past(field)))
        else $error("field order went backwards");
    trig_copy_a: assert property (@(posedge mclk) disable iff (reset)
        (state == frc_pkg::S_IDLE && send_req) |=> (hdr[6:5] == $past(ctrl_flags[6:5])))
        else $error("trigger flags not carried");
endmodule : frc_encoder
`default_nettype wire

// >>> design/frc_pkg.sv
// Package for the report frame encoder: field layout, register map, types.
// Assumes one clock domain and a classic Wishbone register bus.
package frc_pkg;
    // ==========================================================
    // Status byte bit positions
    localparam int ST_TEMP_BIT   = 7;
    localparam int ST_MOTION_BIT = 6;
    localparam int ST_BUTTON_BIT = 5;
    localparam int ST_POS_BIT    = 4;
    localparam int ST_ULCNT_BIT  = 3;
    localparam int ST_DLCNT_BIT  = 2;
    localparam int ST_BATT_BIT   = 1;
    localparam int ST_UNUSED_BIT = 0;
    // ==========================================================
    // Field lengths in bytes
    localparam logic [3:0] LEN_TEMP  = 4'h1;
    localparam logic [3:0] LEN_LAT   = 4'h4;
    localparam logic [3:0] LEN_LON   = 4'h4;
    localparam logic [3:0] LEN_QUAL  = 4'h1;
    localparam logic [3:0] LEN_ULCNT = 4'h1;
    localparam logic [3:0] LEN_DLCNT = 4'h1;
    localparam logic [3:0] LEN_BATT  = 4'h2;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_TEMP    = 8'h04;
    localparam logic [7:0] REG_LAT     = 8'h08;
    localparam logic [7:0] REG_LON     = 8'h0C;
    localparam logic [7:0] REG_MISC    = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;
    localparam logic [7:0] REG_LASTHDR = 8'h18;
    // CTRL fields: bit 0 send (self-clearing), bits 7..1 flags as status byte
    localparam int CTRL_SEND_BIT = 0;
    // MISC fields: quality [7:0], ul counter [15:8], dl counter [23:16]
    localparam int MISC_QUAL_LSB  = 0;
    localparam int MISC_UL_LSB    = 8;
    localparam int MISC_DL_LSB    = 16;
    // TEMP register: temp [7:0], battery [31:16]
    localparam int TEMP_BATT_LSB  = 16;
    // STATUS: bit 0 busy, bits 15..8 frames sent
    localparam int STAT_CNT_LSB   = 8;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    // ==========================================================
    // Frame field order
    typedef enum logic [7:0] {
        F_STATUS = 8'b0000_0001,
        F_TEMP   = 8'b0000_0010,
        F_LAT    = 8'b0000_0100,
        F_LON    = 8'b0000_1000,
        F_QUAL   = 8'b0001_0000,
        F_ULCNT  = 8'b0010_0000,
        F_DLCNT  = 8'b0100_0000,
        F_BATT   = 8'b1000_0000
    } frc_field_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_SEND = 2'b10
    } frc_state_e;
    // Byte on the output stream
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } frc_byte_s;
endpackage : frc_pkg

// >>> design/frc_fifo.sv
// Synchronous valid/ready FIFO for the frame byte stream.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module frc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;
    logic [AW:0]      count;

    assign count     = wr_ptr - rd_ptr;
    // Full when the pointers are a whole depth apart
    assign in_ready  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : frc_fifo
`default_nettype wire

// >>> testbench/frc_sink.sv
// Partner model: the radio uplink that takes the report frame bytes.
// Assumes the encoder's valid/ready byte stream on the single mclk domain.
`timescale 1ns/1ps
`default_nettype none
module frc_sink (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Pace: 0 prompt, 1 every other cycle, 2 stalled
    input  wire logic [1:0] pace,
    // Frame byte stream
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last
);
    // ==========================================================
    // Byte capture and hold check
    frc_pkg::frc_byte_s got[$];
    frc_pkg::frc_byte_s prev;
    int                 hold_bad;
    logic               held;
    always @(posedge mclk) begin
        if (reset) begin
            tx_ready <= 1'b0;
            held     <= 1'b0;
            hold_bad <= 0;
        end else begin
            // Toggled pace catches a source that moves a byte before it is taken
            tx_ready <= (pace == 2'd0) || (pace == 2'd1 && !tx_ready);
            if (held && (tx_valid !== 1'b1 || {tx_last, tx_data} !== prev))
                hold_bad <= hold_bad + 1;
            held <= tx_valid && !tx_ready;
            prev <= {tx_last, tx_data};
            // Raw bytes are kept; degree-minute conversion is the reader's job
            if (tx_valid && tx_ready)
                got.push_back({tx_last, tx_data});
        end
    end
endmodule : frc_sink
`default_nettype wire

// >>> testbench/frc_encoder_bench.sv
// Self-checking bench for the report frame encoder.
// Assumes frc_pkg, frc_fifo, frc_encoder and the frc_sink partner model.
`timescale 1ns/1ps
`default_nettype none
module frc_encoder_bench;
    // ==========================================================
    // Signals
    logic        mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        tx_valid, tx_ready, tx_last;
    logic [7:0]  wb_adr_i, tx_data, hdr_exp;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r_temp, r_lat, r_lon, r_misc;
    logic [1:0]  pace;
    logic [7:0]  exp_q[$];
    int          err_total, cmp_count, frames_exp;

    frc_encoder #(.FIFO_DEPTH(32)) i_frc_encoder (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
    frc_sink i_frc_sink (.mclk(mclk), .reset(reset), .pace(pace), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat, output logic [31:0] rd);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        if (k >= 50) begin
            err_total++;
            final_report();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge mclk);
    endtask : wb

    // Expected bytes worked out from the shadow copies of the registers
    task automatic expect_frame(logic [7:0] flags);
        logic [31:0] pos[2];
        pos = '{r_lat, r_lon};
        hdr_exp = flags & 8'hFE;
        exp_q.push_back(hdr_exp);
        if (flags[7]) exp_q.push_back(r_temp[7:0]);
        if (flags[4]) begin
            foreach (pos[w])
                for (int b = 3; b >= 0; b--)
                    exp_q.push_back(pos[w][8*b+:8] & (b == 0 && w == 0 ? 8'hF1 : 8'hFF));
            exp_q.push_back(r_misc[7:0]);
        end
        if (flags[3]) exp_q.push_back(r_misc[15:8]);
        if (flags[2]) exp_q.push_back(r_misc[23:16]);
        if (flags[1]) begin
            exp_q.push_back(r_temp[31:24]);
            exp_q.push_back(r_temp[23:16]);
        end
        frames_exp++;
    endtask : expect_frame

    task automatic collect(int n);
        logic [31:0] rd;
        int          k, last_at;
        k = 0;
        while (i_frc_sink.got.size() < exp_q.size() && k < 4000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 4000) begin
            err_total++;
            final_report();
        end
        repeat (20) @(posedge mclk);
        check("frame length", exp_q.size(), i_frc_sink.got.size());
        last_at = exp_q.size() / n;
        foreach (exp_q[i]) if (i < i_frc_sink.got.size()) begin
            check("frame byte", exp_q[i], i_frc_sink.got[i].data);
            check("last flag", (i % last_at) == last_at - 1, i_frc_sink.got[i].last);
        end
        check("stream held", 0, i_frc_sink.hold_bad);
        wb(1'b0, frc_pkg::REG_LASTHDR, 32'h0, rd);
        check("last header", hdr_exp, rd);
        wb(1'b0, frc_pkg::REG_STATUS, 32'h0, rd);
        check("status", {frames_exp[7:0], 8'h00}, rd);
        exp_q.delete();
        i_frc_sink.got.delete();
    endtask : collect

    task automatic send(logic [7:0] flags);
        logic [31:0] rd;
        wb(1'b1, frc_pkg::REG_CTRL, {24'h0, flags | 8'h01}, rd);
    endtask : send

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] rd;
        wb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
        for (int a = 0; a <= 28; a += 4) begin
            wb(1'b0, a[7:0], 32'h0, rd);
            check("reset value", 32'h0000_0000, rd);
        end
        // Byte lanes: only lane 1 of the write may land
        wb_sel_i <= 4'h2;
        wb(1'b1, frc_pkg::REG_MISC, 32'hFFFF_FFFF, rd);
        wb_sel_i <= 4'hF;
        wb(1'b0, frc_pkg::REG_MISC, 32'h0, rd);
        check("lane write", 32'h0000_FF00, rd);
    endtask : t_reset

    task automatic t_full;
        logic [31:0] rd;
        r_temp = 32'h0FC9_00F4;
        r_lat  = 32'h4515_969F;
        r_lon  = 32'h0055_345E;
        r_misc = 32'h0020_2127;
        wb(1'b1, frc_pkg::REG_TEMP, r_temp, rd);
        wb(1'b1, frc_pkg::REG_LAT, r_lat, rd);
        wb(1'b1, frc_pkg::REG_LON, r_lon, rd);
        wb(1'b1, frc_pkg::REG_MISC, r_misc, rd);
        expect_frame(8'hFE);
        send(8'hFE);
        collect(1);
        expect_frame(8'h9C);
        send(8'h9C);
        collect(1);
    endtask : t_full

    // One flag at a time with the sink pacing every other cycle, then none with a prompt sink
    task automatic t_each_flag;
        for (int b = 7; b >= 0; b--) begin
            pace <= (b == 0) ? 2'd0 : 2'd1;
            expect_frame(b == 0 ? 8'h00 : 8'h01 << b);
            send(b == 0 ? 8'h00 : 8'h01 << b);
            collect(1);
        end
    endtask : t_each_flag

    // A second send while the first frame is still going is ignored
    task automatic t_busy;
        pace <= 2'd2;
        expect_frame(8'hFE);
        send(8'hFE);
        send(8'h81);
        repeat (40) @(posedge mclk);
        check("stalled count", 0, i_frc_sink.got.size());
        pace <= 2'd0;
        collect(1);
    endtask : t_busy

    // Three full frames overrun the 32-word buffer while the sink stalls
    task automatic t_fifo;
        logic [31:0] rd;
        int          k;
        pace <= 2'd2;
        for (int f = 0; f < 3; f++) begin
            expect_frame(8'hFE);
            send(8'hFE);
            k = 0;
            rd = 32'h1;
            while (f < 2 && rd[0] !== 1'b0 && k < 300) begin
                wb(1'b0, frc_pkg::REG_STATUS, 32'h0, rd);
                k++;
            end
            check("idle before refill", 0, k >= 300);
            if (k >= 300) final_report();
        end
        repeat (60) @(posedge mclk);
        check("stalled count", 0, i_frc_sink.got.size());
        pace <= 2'd1;
        collect(3);
    endtask : t_fifo

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        pace = 2'd0;
        {err_total, cmp_count, frames_exp} = '0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_full();
        t_each_flag();
        t_busy();
        t_fifo();
        final_report();
    end
endmodule : frc_encoder_bench
`default_nettype wire
